/* File: verif/ccu_engine_model.sv */
// execution engine model: apb master issuing operations
`timescale 1ns/1ps
module ccu_engine_model (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  output logic hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // ====================================
  // one transfer; bounded wait so a dead slave cannot hang the run
  task xfer(input logic w, input logic [11:0] ad, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung = hung | (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : ccu_engine_model

/* File: verif/ccu_unit_checker.sv */
// assertions on the compare and convert unit pins
`timescale 1ns/1ps
`include "ccu_cfg.svh"
module ccu_unit_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic fatal_stop
);
  // ====================================
  // helpers
  logic go_wr;
  logic rd_setup;
  assign go_wr = psel && penable && pwrite && paddr == `CCU_APB_GO;
  assign rd_setup = psel && !penable && !pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ====================================
  // properties
  fatal_sticky_a: assert property (fatal_stop |=> fatal_stop)
    else $error("fatal stop dropped");
  fatal_cause_a: assert property ($rose(fatal_stop) |-> $past(go_wr))
    else $error("fatal stop without a start");
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("access phase not answered");
  unmapped_err_a: assert property (psel && penable && paddr > `CCU_APB_GO |-> pslverr)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (psel && penable && paddr <= `CCU_APB_GO && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  unmapped_zero_a: assert property (rd_setup && paddr > `CCU_APB_GO |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!rd_setup |=> $stable(prdata))
    else $error("read data moved outside a read");
  stat_fatal_a: assert property (rd_setup && paddr == `CCU_APB_STAT && fatal_stop |=> prdata[5])
    else $error("status misses fatal bit");
  cover property (go_wr);
  cover property ($rose(fatal_stop));
  cover property (psel && penable && pslverr);
endmodule : ccu_unit_checker

/* File: verif/ccu_unit_tb_top.sv */
// self-checking bench for the compare and convert unit
`timescale 1ns/1ps
`include "ccu_cfg.svh"
module ccu_unit_tb_top;
  typedef struct {logic [31:0] c, a, b, s, m, e; logic st;} ccu_row_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, fatal_stop, hung;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int n_errors, cmp_count;
  logic [7:0] glyph [16] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
    8'h7f, 8'h67, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  // rows are ctrl, opa, opb, descriptor, mask, expected, read stat; ctrl [7:5] relation, [9:8] stack op, [10] stack, [11] bad address, [12] power flow
  ccu_row_t rows[$] = '{
    '{32'h60, 32'h80, 32'h1, 32'h0, 32'h1, 32'h1, 1'b1}, '{32'h61, 32'h8000, 32'h1, 32'h0, 32'h1, 32'h0, 1'b1},
    '{32'h82, 32'hffffffff, 32'h0, 32'h0, 32'h1, 32'h1, 1'b1}, '{32'h23, 32'hbf800000, 32'h3f800000, 32'h0, 32'h1, 32'h0, 1'b1},
    '{32'h43, 32'hbf800000, 32'h3f800000, 32'h0, 32'h1, 32'h1, 1'b1}, '{32'h1001, 32'h5, 32'h5, 32'h0, 32'h1, 32'h1, 1'b1},
    '{32'ha1, 32'h5, 32'h5, 32'h0, 32'h1, 32'h0, 1'b1}, '{32'h4, 32'h41424344, 32'h41424344, 32'h100004, 32'h1, 32'h1, 1'b1},
    '{32'ha4, 32'h41424344, 32'h41424344, 32'h100004, 32'h1, 32'h0, 1'b1}, '{32'h4, 32'h41424344, 32'h41424345, 32'h100004, 32'h1, 32'h0, 1'b1},
    '{32'h4, 32'h41, 32'h41, 32'hff00fe, 32'h1, 32'h1, 1'b1}, '{32'h5, 32'h80, 32'h0, 32'h0, 32'hffff, 32'h80, 1'b0},
    '{32'h6, 32'h12, 32'h0, 32'h0, 32'hff, 32'h12, 1'b0}, '{32'h6, 32'h100, 32'h0, 32'h0, 32'h1c, 32'h4, 1'b1},
    '{32'h6, 32'hffff, 32'h0, 32'h0, 32'hff, 32'h12, 1'b0}, '{32'h7, 32'h8001, 32'h0, 32'h0, 32'hffffffff, 32'hffff8001, 1'b0},
    '{32'h8, 32'hffff8000, 32'h0, 32'h0, 32'hffff, 32'h8000, 1'b0}, '{32'h8, 32'h10000, 32'h0, 32'h0, 32'hffff, 32'h8000, 1'b0},
    '{32'h9, 32'hfffffffe, 32'h0, 32'h0, 32'hffffffff, 32'hc0000000, 1'b0}, '{32'ha, 32'h9999, 32'h0, 32'h0, 32'hffff, 32'h270f, 1'b0},
    '{32'ha, 32'ha0, 32'h0, 32'h0, 32'h1c, 32'h8, 1'b1}, '{32'ha, 32'h1234, 32'h0, 32'h0, 32'h1c, 32'h10, 1'b1},
    '{32'hb, 32'h270f, 32'h0, 32'h0, 32'hffff, 32'h9999, 1'b0}, '{32'hb, 32'h2710, 32'h0, 32'h0, 32'h1c, 32'h8, 1'b1},
    '{32'hc, 32'hc0300000, 32'h0, 32'h0, 32'hffffffff, 32'hfffffffe, 1'b0}, '{32'hd, 32'h40200000, 32'h0, 32'h0, 32'hffffffff, 32'h3, 1'b0},
    '{32'hd, 32'hc0200000, 32'h0, 32'h0, 32'hffffffff, 32'hfffffffd, 1'b0}, '{32'hc, 32'h7fc00000, 32'h0, 32'h0, 32'h1c, 32'h4, 1'b1},
    '{32'hd, 32'h4f32d05e, 32'h0, 32'h0, 32'h1c, 32'h4, 1'b1}, '{32'h805, 32'h1, 32'h0, 32'h0, 32'hffff001c, 32'h60004, 1'b1},
    '{32'h401, 32'h5, 32'h5, 32'h0, 32'h2, 32'h2, 1'b1}, '{32'h5a1, 32'h5, 32'h5, 32'h0, 32'h2, 32'h0, 1'b1},
    '{32'h601, 32'h5, 32'h5, 32'h0, 32'h2, 32'h2, 1'b1}, '{32'h4a1, 32'h5, 32'h5, 32'h0, 32'h2, 32'h0, 1'b1}};
  ccu_row_t fatal[$] = '{'{32'h4, 32'h0, 32'h0, 32'hff00ff, 32'h0, 32'h0, 1'b1},
    '{32'h4, 32'h0, 32'h0, 32'h40204, 32'h0, 32'h0, 1'b1}, '{32'h3, 32'h7fc00000, 32'h0, 32'h0, 32'h0, 32'h0, 1'b1},
    '{32'h801, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 1'b1}};
  ccu_unit i_ccu_unit (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fatal_stop(fatal_stop));
  ccu_engine_model i_ccu_engine_model (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .hung(hung));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ====================================
  // tasks
  task print_verdict();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t ns got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
    i_ccu_engine_model.xfer(w, ad, d, q);
    if (hung) begin
      n_errors++;
      print_verdict();
    end
  endtask : acc
  task run(input ccu_row_t r);
    acc(1'b1, `CCU_APB_CTRL, r.c);
    acc(1'b1, `CCU_APB_OPA, r.a);
    acc(1'b1, `CCU_APB_OPB, r.b);
    acc(1'b1, `CCU_APB_STRA, r.s);
    acc(1'b1, `CCU_APB_STRB, r.s);
    acc(1'b1, `CCU_APB_GO, 32'h0);
  endtask : run
  task do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset
  // ====================================
  // sequence
  initial begin
    ccu_row_t r;
    rst_n = 1'b0;
    n_errors = 0;
    cmp_count = 0;
    do_reset();
    acc(1'b0, `CCU_APB_STAT, 32'h0);
    chk(q, 32'h10); // enable out idle
    acc(1'b0, 12'h020, 32'h0);
    chk(q, 32'h0); // unmapped read
    foreach (rows[i]) begin
      run(rows[i]);
      acc(1'b0, rows[i].st ? `CCU_APB_STAT : `CCU_APB_RES, 32'h0);
      chk(q & rows[i].m, rows[i].e);
    end
    // high digit set on purpose: only the low digit may count
    for (int d = 0; d < 16; d++) begin
      r = '{32'he, {24'h0, 4'ha, d[3:0]}, 32'h0, 32'h0, 32'h0, 32'h0, 1'b0};
      run(r);
      acc(1'b0, `CCU_APB_RES, 32'h0);
      chk(q & 32'hff, {24'h0, glyph[d]});
    end
    foreach (fatal[i]) begin
      do_reset();
      run(fatal[i]);
      acc(1'b0, `CCU_APB_STAT, 32'h0);
      chk({31'h0, fatal_stop}, 32'h1);
      chk(q & 32'h20, 32'h20);
    end
    print_verdict();
  end
endmodule : ccu_unit_tb_top
bind ccu_unit ccu_unit_checker i_ccu_unit_checker (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fatal_stop(fatal_stop));

/* File: verilog/ccu_cfg.svh */
// constants for the compare and convert unit
`ifndef CCU_CFG_SVH
`define CCU_CFG_SVH
`define CCU_STR_MAX_LEN 8'hfe
`define CCU_BCD_MAX 16'h270f
`define CCU_BYTE_MAX 16'h00ff
`define CCU_ERR_INDIRECT 16'h0006
`define CCU_ERR_NONE 16'h0000
`define CCU_DEC_NINE 4'h9
`define CCU_EXP_ONE 8'h7f
`define CCU_EXP_HALF 8'h7e
`define CCU_EXP_OVF 8'h9e
`define CCU_CHOP_PRE 6'h20
`define CCU_APB_CTRL 12'h000
`define CCU_APB_OPA 12'h004
`define CCU_APB_OPB 12'h008
`define CCU_APB_STRA 12'h00c
`define CCU_APB_STRB 12'h010
`define CCU_APB_RES 12'h014
`define CCU_APB_STAT 12'h018
`define CCU_APB_GO 12'h01c
`define CCU_RS_LEN 32'h0000_00ff
`endif

/* File: verilog/ccu_pkg.sv */
// types for the compare and convert unit
package ccu_pkg;
  typedef enum logic [2:0] {
    CCU_REL_EQ, CCU_REL_GE, CCU_REL_LE, CCU_REL_GT, CCU_REL_LT, CCU_REL_NE
  } ccu_rel_t;
  typedef enum logic [1:0] {CCU_ST_LOAD, CCU_ST_AND, CCU_ST_OR} ccu_stk_t;
  typedef enum logic [4:0] {
    CCU_OP_CMP_BYTE, CCU_OP_CMP_WORD, CCU_OP_CMP_DWORD, CCU_OP_CMP_REAL, CCU_OP_CMP_STR,
    CCU_OP_BYTE_TO_WORD, CCU_OP_WORD_TO_BYTE, CCU_OP_WORD_TO_DWORD, CCU_OP_DWORD_TO_WORD,
    CCU_OP_DWORD_TO_REAL, CCU_OP_DEC_TO_BIN, CCU_OP_BIN_TO_DEC, CCU_OP_FLOAT_CHOP,
    CCU_OP_FLOAT_ROUND, CCU_OP_SEVEN
  } ccu_op_t;
endpackage : ccu_pkg

/* File: verilog/ccu_unit.sv */
// compare and convert datapath with apb register access
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`include "ccu_cfg.svh"
module ccu_unit
  import ccu_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fatal_stop
);
  // ================================================================
  // reset release
  logic rst_s1_r, rst_s2_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  wire logic rst_i_n = rst_s2_r;

  // ================================================================
  // registers
  // ctrl: [4:0] op, [7:5] relation, [9:8] stack op, [10] stack mode,
  // [11] indirect address bad, [12] power flow in (ignored by compares)
  logic [12:0] ctrl_r;
  logic [31:0] opa_r, opb_r;
  // string descriptors: [7:0] length, [15:8] start, [23:16] area size
  logic [23:0] stra_r, strb_r;
  logic [31:0] res_r;
  logic result_bit_r, stack_top_r, ovf_r, dec_bad_r, enable_out_r, fatal_r;
  logic [15:0] err_code_r;

  wire logic wr_en = psel && penable && pwrite;
  wire logic go = wr_en && paddr == `CCU_APB_GO;
  wire logic mapped = paddr == `CCU_APB_CTRL || paddr == `CCU_APB_OPA || paddr == `CCU_APB_OPB ||
    paddr == `CCU_APB_STRA || paddr == `CCU_APB_STRB || paddr == `CCU_APB_RES ||
    paddr == `CCU_APB_STAT || paddr == `CCU_APB_GO;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign fatal_stop = fatal_r;

  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      ctrl_r <= '0;
      opa_r <= '0;
      opb_r <= '0;
      stra_r <= '0;
      strb_r <= '0;
    end else if (wr_en) begin
      if (paddr == `CCU_APB_CTRL) ctrl_r <= pwdata[12:0];
      if (paddr == `CCU_APB_OPA) opa_r <= pwdata;
      if (paddr == `CCU_APB_OPB) opb_r <= pwdata;
      if (paddr == `CCU_APB_STRA) stra_r <= pwdata[23:0];
      if (paddr == `CCU_APB_STRB) strb_r <= pwdata[23:0];
    end
  end

  ccu_op_t op;
  ccu_rel_t rel;
  ccu_stk_t stk;
  assign op = ccu_op_t'(ctrl_r[4:0]);
  assign rel = ccu_rel_t'(ctrl_r[7:5]);
  assign stk = ccu_stk_t'(ctrl_r[9:8]);
  wire logic stack_mode = ctrl_r[10];
  wire logic ind_bad = ctrl_r[11];

  // ================================================================
  // compare
  logic lt_c, eq_c, rel_c, nan_c;
  wire logic nan_a = &opa_r[30:23] && |opa_r[22:0];
  wire logic nan_b = &opb_r[30:23] && |opb_r[22:0];
  always_comb begin
    lt_c = 1'b0;
    eq_c = opa_r == opb_r;
    nan_c = 1'b0;
    unique case (op)
      CCU_OP_CMP_BYTE: begin
        eq_c = opa_r[7:0] == opb_r[7:0];
        lt_c = opa_r[7:0] < opb_r[7:0];
      end
      CCU_OP_CMP_WORD: begin
        eq_c = opa_r[15:0] == opb_r[15:0];
        lt_c = $signed(opa_r[15:0]) < $signed(opb_r[15:0]);
      end
      CCU_OP_CMP_REAL: begin
        // signed real: sign-magnitude ordering, both zeros equal
        nan_c = nan_a || nan_b;
        eq_c = opa_r == opb_r || (opa_r[30:0] == '0 && opb_r[30:0] == '0);
        if (opa_r[31] != opb_r[31]) lt_c = opa_r[31] && !eq_c;
        else if (opa_r[31]) lt_c = opa_r[30:0] > opb_r[30:0];
        else lt_c = opa_r[30:0] < opb_r[30:0];
      end
      default: lt_c = $signed(opa_r) < $signed(opb_r);
    endcase
  end

  // string equality: characters arrive packed in operand words
  logic str_eq_c;
  always_comb begin
    str_eq_c = stra_r[7:0] == strb_r[7:0];
    for (int i = 0; i < 4; i++) begin
      if (i < stra_r[7:0] && opa_r[i*8 +: 8] != opb_r[i*8 +: 8]) str_eq_c = 1'b0;
    end
  end

  always_comb begin
    unique case (rel)
      CCU_REL_EQ: rel_c = eq_c;
      CCU_REL_GE: rel_c = !lt_c;
      CCU_REL_LE: rel_c = lt_c || eq_c;
      CCU_REL_GT: rel_c = !lt_c && !eq_c;
      CCU_REL_LT: rel_c = lt_c;
      CCU_REL_NE: rel_c = !eq_c;
      default: rel_c = 1'b0;
    endcase
    if (op == CCU_OP_CMP_STR) rel_c = (rel == CCU_REL_NE) ? !str_eq_c : str_eq_c;
  end

  function automatic logic str_bad(input logic [23:0] d);
    logic [8:0] endp;
    endp = {1'b0, d[15:8]} + {1'b0, d[7:0]};
    return d[7:0] > `CCU_STR_MAX_LEN || endp > {1'b0, d[23:16]};
  endfunction

  // ================================================================
  // conversions
  logic [31:0] conv_c;
  logic ovf_c, dec_bad_c;
  logic [7:0] exp_c;
  logic [31:0] mag_c, chop_c;
  logic [55:0] shf_c;
  logic rnd_c;
  logic [15:0] bcd_c;
  logic [13:0] bin_c;
  logic [7:0] glyph_c;

  always_comb begin
    logic [31:0] m;
    logic [5:0] msb;
    m = opa_r[31] ? 32'(-opa_r) : opa_r;
    msb = '0;
    for (int i = 0; i < 32; i++) if (m[i]) msb = 6'(i);
    exp_c = opa_r[30:23];
    // chop: shift mantissa by exponent; large exponent means overflow
    // whole part lands at bit 24 and up, fraction below; very small inputs shift out to zero
    shf_c = '0;
    if (exp_c >= `CCU_EXP_ONE && exp_c < `CCU_EXP_OVF) begin
      shf_c = (56'({1'b1, opa_r[22:0]}) << `CCU_CHOP_PRE) >> (`CCU_EXP_OVF - exp_c);
    end else if (exp_c < `CCU_EXP_ONE) begin
      shf_c = 56'({1'b1, opa_r[22:0]}) >> (`CCU_EXP_HALF - exp_c);
    end
    mag_c = shf_c[55:24];
    // half or more rounds magnitude up
    rnd_c = shf_c[23];
    chop_c = opa_r[31] ? 32'(-mag_c) : mag_c;
    dec_bad_c = opa_r[3:0] > `CCU_DEC_NINE || opa_r[7:4] > `CCU_DEC_NINE ||
      opa_r[11:8] > `CCU_DEC_NINE || opa_r[15:12] > `CCU_DEC_NINE;
    // widened before the products so that 9000 cannot wrap
    bin_c = 14'(opa_r[15:12]) * 14'd1000 + 14'(opa_r[11:8]) * 14'd100 +
      14'(opa_r[7:4]) * 14'd10 + 14'(opa_r[3:0]);
    bcd_c = {4'(opa_r[15:0] / 16'd1000), 4'((opa_r[15:0] / 16'd100) % 16'd10),
      4'((opa_r[15:0] / 16'd10) % 16'd10), 4'(opa_r[15:0] % 16'd10)};
    // narrow ops other than byte to word write only their low bits of the result; byte to word clears the upper 16
    conv_c = res_r;
    ovf_c = 1'b0;
    unique case (op)
      CCU_OP_BYTE_TO_WORD: conv_c = {16'h0000, 8'h00, opa_r[7:0]};
      CCU_OP_WORD_TO_BYTE: begin
        if (opa_r[15:0] > `CCU_BYTE_MAX) ovf_c = 1'b1;
        else conv_c = {res_r[31:8], opa_r[7:0]};
      end
      CCU_OP_WORD_TO_DWORD: conv_c = {{16{opa_r[15]}}, opa_r[15:0]};
      CCU_OP_DWORD_TO_WORD: begin
        if (opa_r[31:15] != '0 && opa_r[31:15] != '1) ovf_c = 1'b1;
        else conv_c = {res_r[31:16], opa_r[15:0]};
      end
      CCU_OP_DWORD_TO_REAL: begin
        if (m == '0) conv_c = '0;
        // mantissa bits below 24 are dropped, not rounded
        else conv_c = {opa_r[31], 8'(`CCU_EXP_ONE + 8'(msb)), 23'((m << (6'd31 - msb)) >> 8)};
      end
      CCU_OP_DEC_TO_BIN: if (!dec_bad_c) conv_c = {res_r[31:16], 2'b00, bin_c};
      CCU_OP_BIN_TO_DEC: if (opa_r[15:0] <= `CCU_BCD_MAX) conv_c = {res_r[31:16], bcd_c};
      // nan, infinity or out of range
      CCU_OP_FLOAT_CHOP, CCU_OP_FLOAT_ROUND: begin
        if (&exp_c || exp_c >= `CCU_EXP_OVF || (op == CCU_OP_FLOAT_ROUND && rnd_c && &mag_c[30:0]))
          ovf_c = 1'b1;
        else if (op == CCU_OP_FLOAT_ROUND) conv_c = opa_r[31] ? 32'(-(mag_c + 32'(rnd_c))) : 32'(mag_c + 32'(rnd_c));
        else conv_c = chop_c;
      end
      CCU_OP_SEVEN: conv_c = {res_r[31:8], glyph_c};
      default: conv_c = res_r;
    endcase
  end

  always_comb begin
    unique case (opa_r[3:0])
      4'h0: glyph_c = 8'h3f;
      4'h1: glyph_c = 8'h06;
      4'h2: glyph_c = 8'h5b;
      4'h3: glyph_c = 8'h4f;
      4'h4: glyph_c = 8'h66;
      4'h5: glyph_c = 8'h6d;
      4'h6: glyph_c = 8'h7d;
      4'h7: glyph_c = 8'h07;
      4'h8: glyph_c = 8'h7f;
      4'h9: glyph_c = 8'h67;
      4'ha: glyph_c = 8'h77;
      4'hb: glyph_c = 8'h7c;
      4'hc: glyph_c = 8'h39;
      4'hd: glyph_c = 8'h5e;
      4'he: glyph_c = 8'h79;
      4'hf: glyph_c = 8'h71;
    endcase
  end

  // ================================================================
  // execute on go
  wire logic is_cmp = op inside {CCU_OP_CMP_BYTE, CCU_OP_CMP_WORD, CCU_OP_CMP_DWORD,
    CCU_OP_CMP_REAL, CCU_OP_CMP_STR};
  logic fatal_nxt;
  assign fatal_nxt = is_cmp && (ind_bad || (op == CCU_OP_CMP_REAL && nan_c) ||
    (op == CCU_OP_CMP_STR && (str_bad(stra_r) || str_bad(strb_r))));

  // fatal is sticky until reset: the engine must halt and nothing resumes it
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) fatal_r <= 1'b0;
    else if (go && !fatal_r && fatal_nxt) fatal_r <= 1'b1;
  end

  // compare ignores power flow bit ctrl_r[12]
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      result_bit_r <= 1'b0;
      stack_top_r <= 1'b0;
    end else if (go && !fatal_r && is_cmp && !fatal_nxt) begin
      result_bit_r <= rel_c;
      if (stack_mode) begin
        unique case (stk)
          CCU_ST_AND: stack_top_r <= stack_top_r & rel_c;
          CCU_ST_OR: stack_top_r <= stack_top_r | rel_c;
          default: stack_top_r <= rel_c;
        endcase
      end
    end
  end

  // flags land with the result write, except enable_out_r and err_code_r on a bad indirect address
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) begin
      res_r <= '0;
      ovf_r <= 1'b0;
      dec_bad_r <= 1'b0;
      enable_out_r <= 1'b1;
      err_code_r <= `CCU_ERR_NONE;
    end else if (go && !fatal_r && !is_cmp) begin
      // indirect address error
      // the operation never ran, so result, ovf_r and dec_bad_r keep their old values
      if (ind_bad) begin
        enable_out_r <= 1'b0;
        err_code_r <= `CCU_ERR_INDIRECT;
      end else begin
        res_r <= conv_c;
        ovf_r <= ovf_c;
        dec_bad_r <= (op == CCU_OP_DEC_TO_BIN && dec_bad_c) ||
          (op == CCU_OP_BIN_TO_DEC && opa_r[15:0] > `CCU_BCD_MAX);
        enable_out_r <= !(ovf_c || (op == CCU_OP_DEC_TO_BIN && dec_bad_c) ||
          (op == CCU_OP_BIN_TO_DEC && opa_r[15:0] > `CCU_BCD_MAX));
        err_code_r <= `CCU_ERR_NONE;
      end
    end
  end

  // ================================================================
  // read data
  always_ff @(posedge clk or negedge rst_i_n) begin
    if (!rst_i_n) prdata <= '0;
    // loaded in the setup cycle so it stands through the access phase
    else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CCU_APB_CTRL: prdata <= {19'h00000, ctrl_r};
        `CCU_APB_OPA: prdata <= opa_r;
        `CCU_APB_OPB: prdata <= opb_r;
        `CCU_APB_STRA: prdata <= {8'h00, stra_r};
        `CCU_APB_STRB: prdata <= {8'h00, strb_r};
        `CCU_APB_RES: prdata <= res_r;
        `CCU_APB_STAT: prdata <= {err_code_r, 10'h000, fatal_r, enable_out_r, dec_bad_r, ovf_r,
          stack_top_r, result_bit_r};
        default: prdata <= '0;
      endcase
    end
  end
endmodule : ccu_unit
